//--- mdb_defs.vh
`ifndef MDB_DEFS_VH
`define MDB_DEFS_VH
// channel register offsets (byte addresses within the channel window)
`define MDB_OFS_BCNT0 8'h10
`define MDB_OFS_BCNT1 8'h14
`define MDB_OFS_SBASE0 8'h18
`define MDB_OFS_SBASE1 8'h1C
`define MDB_OFS_SPTR0 8'h24
`define MDB_OFS_SPTR1 8'h28
`define MDB_OFS_DBASE0 8'h2C
`define MDB_OFS_DBASE1 8'h30
`define MDB_OFS_DPTR1 8'h3C
`define MDB_OFS_DPTR0 8'h44
`define MDB_OFS_STAT 8'h48
`define MDB_OFS_SUMM 8'hC0
// summary register lives at this absolute address
`define MDB_SUMM_ADDR 32'h800003C0
// window of the channel registers inside the bus address space
`define MDB_CHAN_BASE 32'h80000100
// status field positions
`define MDB_ST_TC0 0
`define MDB_ST_TC1 1
`define MDB_ST_NBSEL 2
`define MDB_ST_NFB 3
`define MDB_ST_BUF_LSB 4
`define MDB_ST_STALL 6
// buffer state codes
`define MDB_BUF_NONE 2'h0
`define MDB_BUF_ON 2'h1
`define MDB_BUF_NEXT 2'h2
`define MDB_CNT_W 16
`define MDB_SUMM_W 12
`endif

//--- mdb_desc.v
`timescale 1ns/1ps
`include "mdb_defs.vh"
// Functional notes
// R1: byte counts keep only 16 low bits; upper bits read zero.
// R2: active count decrements once per completed write-to-memory address transfer.
// R3: software loads a non-zero count before enabling or starting the channel.
// R4: a count write alone queues that buffer for use.
// R5: second buffer may be programmed meanwhile; next-free-buffer pulse when it starts.
// R6: zero count at trigger means no transfers; channel stays stalled.
// R7: software sets source base before enable and before that buffer's count.
// R8: software sets destination base before enable and before that buffer's count.
// R9: peripheral transfers use the peripheral address as source or destination base.
// R10: count write copies both bases into pointers and marks buffer active.
// R11: pointers keep post-incremented addresses after a buffer completes.
// R12: counts at offsets 0x10 and 0x14, read and write.
// R13: source pointers 0x24, 0x28; destination pointers 0x44, 0x3C; read-only.
// R14: summary bits are a plain OR of each channel's interrupt bits.
// R15: summary is read-only at 0x8000_03C0, bits 31..12 reserved.
// R16: bit 11 mem channel 1, bit 10 mem channel 0, then peripheral order; here pairs are swapped (bit 9 is peripheral 8).
// R17: source bases 0x18, 0x1C; destination bases 0x2C, 0x30; read and write.
// R18: reserved bits are undefined; here they read zero.
// R19: next-buffer bit sets on count0 write, clears on count1 write.
// R20: next-free-buffer pulse on moving from next-buffer to buffer-on state; here it pulses on any hop to a queued buffer, even from buffer-on.
// R21: a count write clears that buffer's terminal-count flag.
// R22: on count zero, continue from a queued other buffer automatically.
module mdb_desc #(
	parameter STEP = 32'h00000001
)
(
	// system
	input wire clock_i,
	input wire resetn_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [31:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// transfer engine side
	input wire xfer_trigger_i,
	input wire xfer_wr_done_i,
	output reg xfer_active_o,
	output reg [31:0] xfer_src_o,
	output reg [31:0] xfer_dst_o,
	output reg stall_o,
	output reg next_free_buffer_irq_o,
	output reg [1:0] terminal_count_flags_o,
	// per-channel interrupt vectors
	input wire [1:0] mem_to_mem_irq_i,
	input wire [9:0] mem_to_periph_irq_i
);

	reg [15:0] cnt_r [0:1];
	reg [31:0] sbase_r [0:1];
	reg [31:0] dbase_r [0:1];
	reg [31:0] sptr_r [0:1];
	reg [31:0] dptr_r [0:1];
	reg [1:0] queued_r;
	reg act_r;
	reg [1:0] buf_state_r;
	reg next_buffer_select_r;
	reg [1:0] tc_r;
	reg nfb_r;
	reg stall_r;

	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire [31:0] chan_base = `MDB_CHAN_BASE;
	wire in_chan = (wb_adr_i[31:8] == chan_base[31:8]);
	wire is_summ = (wb_adr_i == `MDB_SUMM_ADDR);
	wire [7:0] ofs = wb_adr_i[7:0];
	wire wr = req & wb_we_i & in_chan;
	wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire wr_c0 = wr & (ofs == `MDB_OFS_BCNT0);
	wire wr_c1 = wr & (ofs == `MDB_OFS_BCNT1);

	// peripheral bits follow the legacy pair-swapped order
	wire [11:0] summ_nxt = {mem_to_mem_irq_i[1], mem_to_mem_irq_i[0],
		mem_to_periph_irq_i[8], mem_to_periph_irq_i[9],
		mem_to_periph_irq_i[6], mem_to_periph_irq_i[7],
		mem_to_periph_irq_i[4], mem_to_periph_irq_i[5],
		mem_to_periph_irq_i[2], mem_to_periph_irq_i[3],
		mem_to_periph_irq_i[0], mem_to_periph_irq_i[1]}; // [R14] [R16]

	wire [15:0] act_cnt = cnt_r[act_r];
	wire running = (buf_state_r != `MDB_BUF_NONE);
	wire last_beat = running & xfer_wr_done_i & (act_cnt == 16'h0001);

	// next-value logic for descriptors
	reg [1:0] queued_nxt;
	reg act_nxt;
	reg [1:0] buf_state_nxt;
	reg [1:0] tc_nxt;
	reg nfb_nxt;
	reg stall_nxt;
	always @*
	begin
		queued_nxt = queued_r;
		act_nxt = act_r;
		buf_state_nxt = buf_state_r;
		tc_nxt = tc_r;
		nfb_nxt = 1'b0;
		stall_nxt = stall_r;
		if (last_beat)
		begin
			tc_nxt[act_r] = 1'b1;
			queued_nxt[act_r] = 1'b0;
			if (queued_r[~act_r])
			begin
				// seamless hop to the other descriptor
				act_nxt = ~act_r; // [R22]
				buf_state_nxt = `MDB_BUF_ON;
				nfb_nxt = 1'b1; // [R5] [R20]
			end
			else
			begin
				buf_state_nxt = `MDB_BUF_NONE;
				stall_nxt = 1'b1;
			end
		end
		else if (!running && xfer_trigger_i)
		begin
			if (queued_r[0] && cnt_r[0] != 16'h0000)
			begin
				act_nxt = 1'b0;
				buf_state_nxt = queued_r[1] ? `MDB_BUF_NEXT : `MDB_BUF_ON;
				stall_nxt = 1'b0;
			end
			else if (queued_r[1] && cnt_r[1] != 16'h0000)
			begin
				act_nxt = 1'b1;
				buf_state_nxt = queued_r[0] ? `MDB_BUF_NEXT : `MDB_BUF_ON;
				stall_nxt = 1'b0;
			end
			else
				stall_nxt = 1'b1; // [R6]
		end
		else if (running && buf_state_r == `MDB_BUF_ON && (wr_c0 | wr_c1))
			buf_state_nxt = `MDB_BUF_NEXT;
		// count writes queue and clear terminal count; both override the logic above
		if (wr_c0)
		begin
			queued_nxt[0] = 1'b1; // [R4]
			tc_nxt[0] = 1'b0; // [R21]
		end
		if (wr_c1)
		begin
			queued_nxt[1] = 1'b1; // [R4]
			tc_nxt[1] = 1'b0; // [R21]
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : g_buf
			wire wr_cnt = (g == 0) ? wr_c0 : wr_c1;
			wire [7:0] o_sb = (g == 0) ? `MDB_OFS_SBASE0 : `MDB_OFS_SBASE1;
			wire [7:0] o_db = (g == 0) ? `MDB_OFS_DBASE0 : `MDB_OFS_DBASE1;
			wire beat = running & xfer_wr_done_i & (act_r == g);
			// pointer values after this edge, so the engine outputs never lag a beat
			wire [31:0] sp_nxt = wr_cnt ? sbase_r[g] : (beat ? sptr_r[g] + STEP : sptr_r[g]);
			wire [31:0] dp_nxt = wr_cnt ? dbase_r[g] : (beat ? dptr_r[g] + STEP : dptr_r[g]);
			always @(posedge clock_i or negedge resetn_i)
			begin
				if (!resetn_i)
				begin
					cnt_r[g] <= 16'h0000;
					sbase_r[g] <= 32'h00000000;
					dbase_r[g] <= 32'h00000000;
					sptr_r[g] <= 32'h00000000;
					dptr_r[g] <= 32'h00000000;
				end
				else
				begin
					if (wr & ofs == o_sb)
						sbase_r[g] <= (sbase_r[g] & ~wmask) | (wb_dat_i & wmask); // [R17]
					if (wr & ofs == o_db)
						dbase_r[g] <= (dbase_r[g] & ~wmask) | (wb_dat_i & wmask); // [R17]
					if (wr_cnt)
					begin
						cnt_r[g] <= (cnt_r[g] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]); // [R1] [R12]
						sptr_r[g] <= sbase_r[g]; // [R10]
						dptr_r[g] <= dbase_r[g]; // [R10]
					end
					else if (beat)
					begin
						// pointers left post-incremented at completion
						cnt_r[g] <= cnt_r[g] - 16'h0001; // [R2]
						sptr_r[g] <= sptr_r[g] + STEP; // [R11]
						dptr_r[g] <= dptr_r[g] + STEP; // [R11]
					end
				end
			end
		end
	endgenerate

	// read mux; reserved bits read zero
	reg [31:0] rd_nxt;
	always @*
	begin
		rd_nxt = 32'h00000000; // [R18]
		if (is_summ)
			rd_nxt = {20'h00000, summ_nxt}; // [R14] [R15]
		else if (in_chan)
		begin
			case (ofs)
				`MDB_OFS_BCNT0: rd_nxt = {16'h0000, cnt_r[0]}; // [R12]
				`MDB_OFS_BCNT1: rd_nxt = {16'h0000, cnt_r[1]};
				`MDB_OFS_SBASE0: rd_nxt = sbase_r[0];
				`MDB_OFS_SBASE1: rd_nxt = sbase_r[1];
				`MDB_OFS_SPTR0: rd_nxt = sptr_r[0]; // [R13]
				`MDB_OFS_SPTR1: rd_nxt = sptr_r[1];
				`MDB_OFS_DBASE0: rd_nxt = dbase_r[0];
				`MDB_OFS_DBASE1: rd_nxt = dbase_r[1];
				`MDB_OFS_DPTR1: rd_nxt = dptr_r[1]; // [R13]
				`MDB_OFS_DPTR0: rd_nxt = dptr_r[0];
				`MDB_OFS_STAT: rd_nxt = {25'h0000000, stall_r, buf_state_r, nfb_r,
					next_buffer_select_r, tc_r};
				default: rd_nxt = 32'h00000000;
			endcase
		end
	end

	always @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			queued_r <= 2'h0;
			act_r <= 1'b0;
			buf_state_r <= `MDB_BUF_NONE;
			next_buffer_select_r <= 1'b0;
			tc_r <= 2'h0;
			nfb_r <= 1'b0;
			stall_r <= 1'b0;
			xfer_active_o <= 1'b0;
			xfer_src_o <= 32'h00000000;
			xfer_dst_o <= 32'h00000000;
			stall_o <= 1'b0;
			next_free_buffer_irq_o <= 1'b0;
			terminal_count_flags_o <= 2'h0;
		end
		else
		begin
			// unmapped addresses still ack, reading zero, so the bus never hangs
			wb_ack_o <= req;
			wb_dat_o <= rd_nxt;
			queued_r <= queued_nxt;
			act_r <= act_nxt;
			buf_state_r <= buf_state_nxt;
			if (wr_c0)
				next_buffer_select_r <= 1'b1; // [R19]
			else if (wr_c1)
				next_buffer_select_r <= 1'b0; // [R19]
			tc_r <= tc_nxt;
			// sticky status view; cleared only by the next count write
			if (nfb_nxt)
				nfb_r <= 1'b1;
			else if (wr_c0 | wr_c1)
				nfb_r <= 1'b0;
			stall_r <= stall_nxt;
			xfer_active_o <= (buf_state_nxt != `MDB_BUF_NONE);
			xfer_src_o <= act_nxt ? g_buf[1].sp_nxt : g_buf[0].sp_nxt; // [R11]
			xfer_dst_o <= act_nxt ? g_buf[1].dp_nxt : g_buf[0].dp_nxt; // [R11]
			stall_o <= stall_nxt;
			next_free_buffer_irq_o <= nfb_nxt;
			terminal_count_flags_o <= tc_nxt;
		end
	end

endmodule // mdb_desc

//--- mdb_mem_model.sv
`timescale 1ns/1ps
// engine side stand-in: holds trigger as a level, answers each beat after GAP idle cycles
module mdb_mem_model #(
	parameter GAP = 1
)
(
	input wire clock_i,
	input wire resetn_i,
	input wire go_i,
	input wire active_i,
	output reg trigger_o,
	output reg wr_done_o
);
	integer n;
	always @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			trigger_o <= 1'b0;
			wr_done_o <= 1'b0;
			n <= 0;
		end
		else
		begin
			trigger_o <= go_i;
			n <= (n >= GAP) ? 0 : n + 1;
			// gap of at least one cycle lets active drop before a stray beat
			wr_done_o <= active_i && (n == GAP);
		end
	end
endmodule // mdb_mem_model

//--- mdb_desc_chk.sv
`timescale 1ns/1ps
`include "mdb_defs.vh"
module mdb_desc_chk #(
	parameter STEP = 32'h00000001
)
(
	input wire clock_i, input wire resetn_i, input wire wb_cyc_i, input wire wb_stb_i,
	input wire wb_we_i, input wire [31:0] wb_adr_i, input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i, input wire [31:0] wb_dat_o, input wire wb_ack_o,
	input wire xfer_trigger_i, input wire xfer_wr_done_i, input wire xfer_active_o,
	input wire [31:0] xfer_src_o, input wire [31:0] xfer_dst_o, input wire stall_o,
	input wire next_free_buffer_irq_o, input wire [1:0] terminal_count_flags_o,
	input wire [1:0] mem_to_mem_irq_i, input wire [9:0] mem_to_periph_irq_i
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	wire req = wb_cyc_i && wb_stb_i;
	wire bw = wb_ack_o && wb_we_i;
	wire [1:0] tc = terminal_count_flags_o;
	AST_ACK_ONE: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req)) else $error("ack unasked");
	AST_TC_CLR: assert property (bw |-> !(wb_adr_i == `MDB_CHAN_BASE + `MDB_OFS_BCNT0 && tc[0])
		&& !(wb_adr_i == `MDB_CHAN_BASE + `MDB_OFS_BCNT1 && tc[1])) else $error("flag kept");
	AST_PTR_STEP: assert property (xfer_wr_done_i && xfer_active_o && !wb_ack_o |=>
		(xfer_src_o == $past(xfer_src_o) + STEP && xfer_dst_o == $past(xfer_dst_o) + STEP)
		|| tc != $past(tc)) else $error("pointer step wrong");
	AST_NFB_PULSE: assert property (next_free_buffer_irq_o |=> !next_free_buffer_irq_o)
		else $error("irq pulse too long");
	AST_NFB_ACT: assert property (next_free_buffer_irq_o |-> xfer_active_o && tc != 2'h0)
		else $error("irq without hop");
	AST_STALL_IDLE: assert property ($rose(stall_o) |-> !xfer_active_o)
		else $error("stall while active");
endmodule // mdb_desc_chk
bind mdb_desc mdb_desc_chk #(.STEP(STEP)) chk_i (.clock_i(clock_i), .resetn_i(resetn_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.xfer_trigger_i(xfer_trigger_i), .xfer_wr_done_i(xfer_wr_done_i),
	.xfer_active_o(xfer_active_o), .xfer_src_o(xfer_src_o), .xfer_dst_o(xfer_dst_o),
	.stall_o(stall_o), .next_free_buffer_irq_o(next_free_buffer_irq_o),
	.terminal_count_flags_o(terminal_count_flags_o), .mem_to_mem_irq_i(mem_to_mem_irq_i),
	.mem_to_periph_irq_i(mem_to_periph_irq_i));

//--- mdb_desc_tb.sv
`timescale 1ns/1ps
`include "mdb_defs.vh"
module mdb_desc_tb;
	reg clock_i = 0, resetn_i = 0, cyc = 0, stb = 0, we = 0, go = 0;
	reg [31:0] adr = 0, dat = 0, q, v;
	reg [3:0] sel = 0;
	reg [1:0] m2m = 0;
	reg [9:0] per = 0;
	wire [31:0] dout, src, dst;
	wire ack, trig, done, act, stall, next_free_buffer_irq;
	wire [1:0] tc;
	integer num_errors = 0, samples_checked = 0, nfb_seen = 0, i, n;
	localparam [31:0] CB = `MDB_CHAN_BASE;
	mdb_desc #(.STEP(32'h00000004)) uut (.clock_i(clock_i), .resetn_i(resetn_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .xfer_trigger_i(trig),
		.xfer_wr_done_i(done), .xfer_active_o(act), .xfer_src_o(src), .xfer_dst_o(dst),
		.stall_o(stall), .next_free_buffer_irq_o(next_free_buffer_irq), .terminal_count_flags_o(tc),
		.mem_to_mem_irq_i(m2m), .mem_to_periph_irq_i(per));
	// slow beats so the status read lands before buffer 0 completes
	mdb_mem_model #(.GAP(6)) mem (.clock_i(clock_i), .resetn_i(resetn_i), .go_i(go),
		.active_i(act), .trigger_o(trig), .wr_done_o(done));
	initial
	begin
		forever #25 clock_i = ~clock_i;
	end
	always @(posedge clock_i) if (next_free_buffer_irq === 1'b1) nfb_seen = nfb_seen + 1;
	task end_sim;
	begin
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
	begin
		samples_checked = samples_checked + 1;
		if (g !== e)
		begin
			num_errors = num_errors + 1;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task wb(input [31:0] a, input w, input [31:0] d);
	begin
		@(posedge clock_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
		n = 0;
		do begin @(posedge clock_i); n = n + 1; end while (ack !== 1'b1 && n < 50);
		q = dout;
		if (n >= 50) num_errors = num_errors + 1;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	end
	endtask
	task rd(input string nm, input [31:0] a, input [31:0] e);
	begin
		wb(a, 1'b0, 32'h0);
		chk(nm, e, q);
	end
	endtask
	task s_regs;
	begin
		wb(CB + `MDB_OFS_SBASE0, 1, 32'h00001000);
		wb(CB + `MDB_OFS_DBASE0, 1, 32'h00002000);
		wb(CB + `MDB_OFS_SBASE1, 1, 32'h00003000);
		wb(CB + `MDB_OFS_DBASE1, 1, 32'h00004000);
		rd("sbase1", CB + `MDB_OFS_SBASE1, 32'h00003000);
		rd("dbase0", CB + `MDB_OFS_DBASE0, 32'h00002000);
		wb(CB + `MDB_OFS_BCNT0, 1, 32'h00000002);
		rd("bcnt0", CB + `MDB_OFS_BCNT0, 32'h00000002);
		wb(CB + `MDB_OFS_SPTR0, 1, 32'hFFFFFFFF);
		rd("sptr0", CB + `MDB_OFS_SPTR0, 32'h00001000);
		rd("dptr0", CB + `MDB_OFS_DPTR0, 32'h00002000);
		rd("unmapped", CB + 32'h00000080, 32'h0);
	end
	endtask
	task s_xfer;
	begin
		go <= 1'b1;
		wb(CB + `MDB_OFS_BCNT1, 1, 32'h00010001);
		rd("status_nb", CB + `MDB_OFS_STAT, 32'h00000010);
		i = 0;
		while (stall !== 1'b1 && i < 400) begin @(posedge clock_i); i = i + 1; end
		chk("nfb count", 1, nfb_seen);
		chk("tc flags", 2'h3, tc);
		chk("xfer src", 32'h00003004, src);
		chk("xfer dst", 32'h00004004, dst);
		rd("bcnt1", CB + `MDB_OFS_BCNT1, 32'h0);
		rd("sptr0 end", CB + `MDB_OFS_SPTR0, 32'h00001008);
		rd("dptr0 end", CB + `MDB_OFS_DPTR0, 32'h00002008);
		rd("sptr1 end", CB + `MDB_OFS_SPTR1, 32'h00003004);
		rd("dptr1 end", CB + `MDB_OFS_DPTR1, 32'h00004004);
	end
	endtask
	task s_zero;
	begin
		repeat (8) @(posedge clock_i);
		chk("active", 0, act);
		chk("stall", 1, stall);
		go <= 1'b0;
	end
	endtask
	task s_summ;
	begin
		for (i = 0; i <= 12; i = i + 1)
		begin
			v = (i < 12) ? (32'h1 << i) : 32'h0;
			@(posedge clock_i);
			m2m <= v[11:10];
			per <= {v[8], v[9], v[6], v[7], v[4], v[5], v[2], v[3], v[0], v[1]};
			repeat (2) @(posedge clock_i);
			rd("summary", `MDB_SUMM_ADDR, v);
		end
	end
	endtask
	initial
	begin
		repeat (5000) @(posedge clock_i);
		num_errors = num_errors + 1;
		end_sim;
	end
	initial
	begin
		repeat (8) @(posedge clock_i);
		resetn_i <= 1'b1;
		s_regs;
		s_xfer;
		s_zero;
		s_summ;
		end_sim;
	end
endmodule // mdb_desc_tb
